// ### tsa_pkg.sv
package tsa_pkg;
  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_PS    = 8000;
  localparam int unsigned AUX_WINDOW_US    = 250;
  // longest time, rounds down
  localparam int unsigned AUX_WINDOW_CYC   = AUX_WINDOW_US * 1000000 / CLK_PERIOD_PS;
  localparam int unsigned AUX_MIN_PATTERNS = 254;
  localparam int unsigned CRC_WINDOW       = 1000;
  localparam int unsigned CRC_THRESHOLD    = 915;
  localparam int unsigned MFL_BAD_WORDS    = 2;
  localparam int unsigned MFL_ZERO_FRAMES  = 16;
  localparam int unsigned AIS_MAX_ZEROS    = 3;
  localparam int unsigned AIS_MF_COUNT     = 2;
  localparam int unsigned RAI_COUNT        = 3;
  ////////////////////////////////////////////////////////////////////////
  // register indexes, byte address is four times the index
  localparam logic [9:0] REG_CHAN_CFG  = 10'h003;
  localparam logic [9:0] REG_GLOBAL    = 10'h00b;
  localparam logic [9:0] REG_LIVE      = 10'h164;
  localparam logic [9:0] REG_LATCHED   = 10'h165;
  localparam logic [9:0] REG_MASK      = 10'h166;
  localparam logic [9:0] REG_SECOND    = 10'h167;
  localparam logic [9:0] REG_PERSIST   = 10'h168;
  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned CFG_MFL_EN_BIT   = 1;
  localparam int unsigned CFG_AUX_EN_BIT   = 2;
  localparam int unsigned GLB_RISE_BIT     = 0;
  localparam int unsigned GLB_FALL_BIT     = 1;
  localparam int unsigned GLB_SHADOW_BIT   = 3;
  localparam int unsigned GLB_GRP_MASK_BIT = 6;
  localparam int unsigned GLB_GIM_BIT      = 7;
  localparam int unsigned TS16_RAI_BIT     = 2;
  localparam logic [7:0]  ALARM_BITS       = 8'h75;
  localparam logic [7:0]  CFG_WR_BITS      = 8'h06;
  localparam logic [7:0]  GLB_WR_BITS      = 8'hcb;
  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] GLB_RST  = 8'h01;
  localparam logic [7:0] MASK_RST = 8'h00;

  typedef struct packed {
    logic rsv7;
    logic ais;
    logic crc;
    logic rai;
    logic rsv3;
    logic mfl;
    logic rsv1;
    logic aux;
  } tsa_alarm_t;
endpackage

// ### tsa_debounce.sv
`timescale 1ns/1ps
// state flips after n consecutive contrary steps
module tsa_debounce #(
  parameter int unsigned N = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic step_i,
  input  wire logic hit_i,
  input  wire logic force_clr_i,
  output logic      state_o
);
  localparam int unsigned W = $clog2(N + 1);

  logic [W-1:0] run;
  logic         state;

  always_ff @(posedge clk_i) begin
    if (rst_i || force_clr_i) begin
      run   <= '0;
      state <= 1'b0;
    end else if (step_i) begin
      if (hit_i == state) begin
        run <= '0;
      end else if (run == W'(N - 1)) begin
        state <= hit_i;
        run   <= '0;
      end else begin
        run <= W'(run + 1'b1);
      end
    end
  end

  assign state_o = state;
endmodule

// ### tsa_bit_mem.sv
`timescale 1ns/1ps
// one-bit history store, registered read
module tsa_bit_mem #(
  parameter int unsigned DEPTH = 1000,
  parameter int unsigned AW    = 10
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic          wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic               rdata_o
);
  logic mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule

// ### tsa_alarm_status.sv
`timescale 1ns/1ps
// Function
// [RL1] multiframe loss: two bad words or frame lost
// [RL2] multiframe loss: sixteen all-zero slot frames
// [RL3] multiframe loss reported only when enabled
// [RL4] alternating pattern 254 times per window alarms
// [RL5] framing or too few patterns clears it
// [RL6] pattern detection runs only while enabled
// [RL7] live edge per rise/fall select sets latch
// [RL8] unmasked latched bit drives interrupt unless global or group mask set
// [RL9] write zero or shadowed second pulse clears
// [RL10] mask bit one blocks its interrupt
// [RL11] software writes reserved bits as zero
// [RL12] second and persistent bits zero without shadow
// [RL13] second bit: alarm seen during last interval
// [RL14] persistent bit: active but not newly risen
// [RL15] slot AIS: few zeros two multiframes running
// [RL16] excess CRC: 915 of last 1000 bad
// [RL17] slot RAI: bit set three frame-0 words
// [RL18] second registers update on pulse, then hold
module tsa_alarm_status #(
  parameter int unsigned AUX_WIN = tsa_pkg::AUX_WINDOW_CYC
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [11:0]  wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic         one_sec_i,
  input  wire logic         rx_ts16_valid_i,
  input  wire logic [7:0]   rx_ts16_data_i,
  input  wire logic         rx_mf_frame0_i,
  input  wire logic         rx_frame_lost_i,
  input  wire logic         rx_crc4_valid_i,
  input  wire logic         rx_crc4_err_i,
  input  wire logic         rx_line_valid_i,
  input  wire logic         rx_line_bit_i,
  input  wire logic         rx_framed_i,
  output tsa_pkg::tsa_alarm_t alarm_live_o,
  output logic              irq_o
);
  localparam int unsigned WW = $clog2(AUX_WIN + 1);

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  chan_cfg;
  logic [7:0]  glb;
  logic [7:0]  latched;
  logic [7:0]  mask;
  logic [7:0]  sec_err;
  logic [7:0]  persist;
  logic [7:0]  seen;
  logic [7:0]  newly;
  logic [7:0]  prev_live;
  tsa_pkg::tsa_alarm_t live;
  logic [7:0]  live_v;
  logic        req;
  logic        wr_en;
  logic [9:0]  idx;
  logic [7:0]  rd_byte;
  logic        shadow;
  assign req    = wb_cyc_i && wb_stb_i;
  assign idx    = wb_adr_i[11:2];
  assign wr_en  = req && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign shadow = glb[tsa_pkg::GLB_SHADOW_BIT];

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave, one wait state then ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  always_comb begin
    unique case (idx)
      tsa_pkg::REG_CHAN_CFG: rd_byte = chan_cfg;
      tsa_pkg::REG_GLOBAL:   rd_byte = glb;
      tsa_pkg::REG_LIVE:     rd_byte = live_v;
      tsa_pkg::REG_LATCHED:  rd_byte = latched;
      tsa_pkg::REG_MASK:     rd_byte = mask;
      tsa_pkg::REG_SECOND:   rd_byte = sec_err;
      tsa_pkg::REG_PERSIST:  rd_byte = persist;
      default:               rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_ack_o && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // reserved bits stored as zero whatever software writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_cfg <= tsa_pkg::CFG_RST;
      glb      <= tsa_pkg::GLB_RST;
      mask     <= tsa_pkg::MASK_RST;
    end else if (wr_en) begin
      if (idx == tsa_pkg::REG_CHAN_CFG) begin
        chan_cfg <= wb_dat_i[7:0] & tsa_pkg::CFG_WR_BITS;
      end
      if (idx == tsa_pkg::REG_GLOBAL) begin
        glb <= wb_dat_i[7:0] & tsa_pkg::GLB_WR_BITS;
      end
      if (idx == tsa_pkg::REG_MASK) begin
        mask <= wb_dat_i[7:0] & tsa_pkg::ALARM_BITS; // see [RL11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // multiframe loss and slot alarms
  logic ts_f0;
  logic bad_word_db;
  logic zero_run_db;
  logic mf_signal;
  logic ais_db;
  logic rai_db;
  logic [7:0] zcnt;
  logic [7:0] byte_zeros;
  logic       mfl_raw;

  assign ts_f0      = rx_ts16_valid_i && rx_mf_frame0_i;
  assign mf_signal  = ts_f0 && (rx_ts16_data_i[7:4] == 4'h0);
  assign byte_zeros = 8'(8 - $countones(rx_ts16_data_i));

  tsa_debounce #(.N(tsa_pkg::MFL_BAD_WORDS)) u_bad_word (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .step_i      (ts_f0),
    .hit_i       (!mf_signal), // see [RL1]
    .force_clr_i (1'b0),
    .state_o     (bad_word_db)
  );

  tsa_debounce #(.N(tsa_pkg::MFL_ZERO_FRAMES)) u_zero_run (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .step_i      (rx_ts16_valid_i),
    .hit_i       (rx_ts16_data_i == 8'h00), // see [RL2]
    .force_clr_i (1'b0),
    .state_o     (zero_run_db)
  );

  assign mfl_raw = bad_word_db || zero_run_db || rx_frame_lost_i; // see [RL1]

  // zeros per multiframe, judged at next frame 0; ff until one opens, never reads as AIS
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zcnt <= 8'hff;
    end else if (ts_f0) begin
      zcnt <= byte_zeros;
    end else if (rx_ts16_valid_i && zcnt != 8'hff) begin
      zcnt <= 8'(zcnt + byte_zeros);
    end
  end

  tsa_debounce #(.N(tsa_pkg::AIS_MF_COUNT)) u_ais (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .step_i      (ts_f0),
    .hit_i       (zcnt <= 8'(tsa_pkg::AIS_MAX_ZEROS)), // see [RL15]
    .force_clr_i (mf_signal), // see [RL15]
    .state_o     (ais_db)
  );

  tsa_debounce #(.N(tsa_pkg::RAI_COUNT)) u_rai (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .step_i      (ts_f0),
    .hit_i       (rx_ts16_data_i[tsa_pkg::TS16_RAI_BIT]), // see [RL17]
    .force_clr_i (1'b0),
    .state_o     (rai_db)
  );

  ////////////////////////////////////////////////////////////////////////
  // excess crc-4 over a sliding window
  logic [9:0] crc_ptr;
  logic [9:0] crc_count;
  logic       crc_filled;
  logic       crc_old;
  logic       crc_alarm;

  // read data for the current slot is ready one cycle after ptr moves
  tsa_bit_mem #(.DEPTH(tsa_pkg::CRC_WINDOW), .AW(10)) u_crc_hist (
    .clk_i   (clk_i),
    .we_i    (rx_crc4_valid_i),
    .waddr_i (crc_ptr),
    .wdata_i (rx_crc4_err_i),
    .raddr_i (crc_ptr),
    .rdata_o (crc_old)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_ptr    <= 10'h000;
      crc_count  <= 10'h000;
      crc_filled <= 1'b0;
    end else if (rx_crc4_valid_i) begin
      crc_count <= 10'(crc_count + {9'h000, rx_crc4_err_i}
                   - {9'h000, crc_old && crc_filled}); // see [RL16]
      if (crc_ptr == 10'(tsa_pkg::CRC_WINDOW - 1)) begin
        crc_ptr    <= 10'h000;
        crc_filled <= 1'b1;
      end else begin
        crc_ptr <= 10'(crc_ptr + 1'b1);
      end
    end
  end

  assign crc_alarm = crc_count >= 10'(tsa_pkg::CRC_THRESHOLD); // see [RL16]

  ////////////////////////////////////////////////////////////////////////
  // alternating pattern over a fixed window
  logic [WW-1:0] win_cnt;
  logic [7:0]    pat_cnt;
  logic          prev_bit;
  logic          aux;
  logic          aux_en;
  logic          win_end;

  assign aux_en  = chan_cfg[tsa_pkg::CFG_AUX_EN_BIT];
  assign win_end = win_cnt == WW'(AUX_WIN - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i || !aux_en || win_end) begin
      win_cnt <= '0;
    end else begin
      win_cnt <= WW'(win_cnt + 1'b1);
    end
  end

  // a repeated bit breaks the pattern, so count restarts
  always_ff @(posedge clk_i) begin
    if (rst_i || !aux_en || win_end) begin
      pat_cnt  <= 8'h00;
      prev_bit <= 1'b0;
    end else if (rx_line_valid_i) begin
      prev_bit <= rx_line_bit_i;
      if (rx_line_bit_i == prev_bit) begin
        pat_cnt <= 8'h00;
      end else if (!rx_line_bit_i && pat_cnt != 8'hff) begin
        pat_cnt <= 8'(pat_cnt + 1'b1); // see [RL4]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !aux_en || rx_framed_i) begin
      aux <= 1'b0; // see [RL5] [RL6]
    end else if (win_end) begin
      aux <= pat_cnt >= 8'(tsa_pkg::AUX_MIN_PATTERNS); // see [RL4] [RL5]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // live view
  always_comb begin
    live      = '0;
    live.ais  = ais_db;
    live.crc  = crc_alarm;
    live.rai  = rai_db;
    live.mfl  = mfl_raw && chan_cfg[tsa_pkg::CFG_MFL_EN_BIT]; // see [RL3]
    live.aux  = aux;
  end

  assign live_v       = live;
  assign alarm_live_o = live;

  ////////////////////////////////////////////////////////////////////////
  // latched bits and interrupt
  logic [7:0] rise_ev;
  logic [7:0] fall_ev;
  logic [7:0] set_ev;
  logic [7:0] clr_ev;

  assign rise_ev = live_v & ~prev_live;
  assign fall_ev = ~live_v & prev_live;
  assign set_ev  = ((rise_ev & {8{glb[tsa_pkg::GLB_RISE_BIT]}})
                  | (fall_ev & {8{glb[tsa_pkg::GLB_FALL_BIT]}}))
                  & tsa_pkg::ALARM_BITS; // see [RL7]
  assign clr_ev  = ((wr_en && idx == tsa_pkg::REG_LATCHED) ? ~wb_dat_i[7:0] : 8'h00)
                  | ((one_sec_i && shadow) ? 8'hff : 8'h00); // see [RL9]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_live <= 8'h00;
      latched   <= 8'h00;
    end else begin
      prev_live <= live_v;
      // an edge in the clearing cycle still sets
      latched   <= (latched & ~clr_ev) | set_ev; // see [RL7] [RL9]
    end
  end

  assign irq_o = |(latched & ~mask) // see [RL10]
                 && !glb[tsa_pkg::GLB_GIM_BIT]
                 && !glb[tsa_pkg::GLB_GRP_MASK_BIT]; // see [RL8]

  ////////////////////////////////////////////////////////////////////////
  // one-second and persistent indications
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen  <= 8'h00;
      newly <= 8'h00;
    end else if (one_sec_i) begin
      seen  <= live_v;
      newly <= rise_ev;
    end else begin
      seen  <= seen | live_v;
      newly <= newly | rise_ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !shadow) begin
      sec_err <= 8'h00; // see [RL12]
      persist <= 8'h00; // see [RL12]
    end else if (one_sec_i) begin
      sec_err <= (seen | live_v) & tsa_pkg::ALARM_BITS; // see [RL13] [RL18]
      persist <= live_v & ~(newly | rise_ev) & tsa_pkg::ALARM_BITS; // see [RL14] [RL18]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  latch_rise_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [RL7]
    $rose(live.aux) && glb[tsa_pkg::GLB_RISE_BIT] |=> latched[0])
    else $error("rising aux alarm not latched");
  irq_path_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [RL8]
    $rose(live.ais) && glb[tsa_pkg::GLB_RISE_BIT] && !mask[6]
    && !glb[tsa_pkg::GLB_GIM_BIT] && !glb[tsa_pkg::GLB_GRP_MASK_BIT]
    && !wr_en ##1 !$changed(glb) && !$changed(mask) |-> irq_o)
    else $error("unmasked latched alarm gave no interrupt");
  write_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [RL9]
    wr_en && idx == tsa_pkg::REG_LATCHED && !wb_dat_i[0] && !set_ev[0] |=> !latched[0])
    else $error("latched bit survived write of zero");
  shadow_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [RL12]
    !shadow |=> sec_err == 8'h00 && persist == 8'h00)
    else $error("second bits set without shadow enable");
  sec_seen_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [RL13]
    shadow && one_sec_i && live.crc |=> sec_err[5])
    else $error("second error bit missed active alarm");
  persist_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [RL14]
    shadow && one_sec_i && !live.rai |=> !persist[4])
    else $error("persistent bit set for inactive alarm");
  mfl_enable_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [RL3]
    !chan_cfg[tsa_pkg::CFG_MFL_EN_BIT] || rx_frame_lost_i
    |-> live.mfl == (chan_cfg[tsa_pkg::CFG_MFL_EN_BIT] && rx_frame_lost_i))
    else $error("multiframe loss report disagrees with enable");
  aux_framed_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [RL5]
    rx_framed_i || !aux_en |=> !aux)
    else $error("pattern alarm held while framed or disabled");
  crc_bound_a: assert property (@(posedge clk_i) disable iff (rst_i) // see [RL16]
    crc_count <= 10'(tsa_pkg::CRC_WINDOW) && (crc_filled || crc_count <= crc_ptr))
    else $error("crc error count out of range");
endmodule

// ### tsa_line_model.sv
`timescale 1ns/1ps
// far end of the received line; slot and crc data go inverse once no longer qualified, the line bit holds,
// so a stale value never passes for a fresh one
module tsa_line_model (
  input  wire logic clk_i,
  output logic       ts16_valid_o,
  output logic [7:0] ts16_data_o,
  output logic       frame0_o,
  output logic       lost_o,
  output logic       crc_valid_o,
  output logic       crc_err_o,
  output logic       line_valid_o,
  output logic       line_bit_o,
  output logic       framed_o
);
  initial begin
    {ts16_valid_o, frame0_o, lost_o, crc_valid_o, crc_err_o} = 5'h00;
    {line_valid_o, line_bit_o, framed_o} = 3'h0;
    ts16_data_o = 8'h5a;
  end
  // one slot octet, all eight bits at once for one cycle
  task automatic octet(input logic [7:0] d, input logic f0);
    @(posedge clk_i);
    ts16_valid_o <= 1'b1;
    ts16_data_o  <= d;
    frame0_o     <= f0;
    @(posedge clk_i);
    ts16_valid_o <= 1'b0;
    ts16_data_o  <= ~d;
    frame0_o     <= ~f0;
  endtask
  // checks two cycles apart, as the block requires
  task automatic crc(input int n, input logic err);
    repeat (n) begin
      @(posedge clk_i);
      crc_valid_o <= 1'b1;
      crc_err_o   <= err;
      @(posedge clk_i);
      crc_valid_o <= 1'b0;
      crc_err_o   <= ~err;
    end
  endtask
  // unframed bits, alternating or a stuck one
  task automatic bits(input int n, input logic alt);
    repeat (n) begin
      @(posedge clk_i);
      line_valid_o <= 1'b1;
      line_bit_o   <= alt ? ~line_bit_o : 1'b1;
    end
    @(posedge clk_i);
    line_valid_o <= 1'b0;
  endtask
  task automatic lvl(input logic lost, input logic framed);
    @(posedge clk_i);
    lost_o   <= lost;
    framed_o <= framed;
  endtask
endmodule

// ### ts16_aux_alarm_status_test.sv
`timescale 1ns/1ps
module ts16_aux_alarm_status_test;
  localparam int unsigned WIN = 600;
  logic                clk_i;
  logic                rst_i;
  logic                cyc;
  logic                stb;
  logic                we;
  logic [11:0]         adr;
  logic [31:0]         dat_w;
  logic [31:0]         dat_r;
  logic                ack;
  logic                one_sec;
  tsa_pkg::tsa_alarm_t live;
  logic                irq;
  logic                tv, f0, lost, cv, ce, lv, lb, framed;
  logic [7:0]          td;
  logic [7:0]          q;
  int                  n_mismatch = 0;
  int                  samples_checked = 0;

  tsa_alarm_status #(.AUX_WIN(WIN)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .one_sec_i(one_sec), .rx_ts16_valid_i(tv), .rx_ts16_data_i(td), .rx_mf_frame0_i(f0),
    .rx_frame_lost_i(lost), .rx_crc4_valid_i(cv), .rx_crc4_err_i(ce),
    .rx_line_valid_i(lv), .rx_line_bit_i(lb), .rx_framed_i(framed),
    .alarm_live_o(live), .irq_o(irq));
  tsa_line_model far (
    .clk_i(clk_i), .ts16_valid_o(tv), .ts16_data_o(td), .frame0_o(f0), .lost_o(lost),
    .crc_valid_o(cv), .crc_err_o(ce), .line_valid_o(lv), .line_bit_o(lb),
    .framed_o(framed));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // callers keep reserved alarm bits at zero
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= {idx, 2'b00};
    dat_w <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) n_mismatch++;
    q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    check({24'h0, q}, {24'h0, exp});
  endtask
  // live alarms and irq after the detectors have settled
  task automatic live_chk(input logic [7:0] exp, input logic exp_irq);
    repeat (4) @(posedge clk_i);
    check({23'h0, irq, live}, {23'h0, exp_irq, exp});
  endtask
  task automatic reset_dut;
    far.lvl(1'b0, 1'b0);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic pulse;
    @(posedge clk_i);
    one_sec <= 1'b1;
    @(posedge clk_i);
    one_sec <= 1'b0;
  endtask
  task automatic rai_words(input logic [7:0] d);
    repeat (3) far.octet(d, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    reset_dut();
    rd_chk(tsa_pkg::REG_CHAN_CFG, tsa_pkg::CFG_RST);
    rd_chk(tsa_pkg::REG_GLOBAL, tsa_pkg::GLB_RST);
    rd_chk(tsa_pkg::REG_LATCHED, 8'h00);
    rd_chk(tsa_pkg::REG_SECOND, 8'h00);
    rd_chk(tsa_pkg::REG_PERSIST, 8'h00);
    rd_chk(tsa_pkg::REG_MASK, tsa_pkg::MASK_RST);
    wr(tsa_pkg::REG_LIVE, 8'h75);
    rd_chk(tsa_pkg::REG_LIVE, 8'h00);
    wr(10'h1ff, 8'h75);
    rd_chk(10'h1ff, 8'h00);
    wr(tsa_pkg::REG_MASK, 8'h75);
    rd_chk(tsa_pkg::REG_MASK, 8'h75);
  endtask
  // two bad words already stand while reporting is off, so enabling reveals them
  task automatic t_mfl;
    reset_dut();
    repeat (2) far.octet(8'hf0, 1'b1);
    live_chk(8'h00, 1'b0);
    wr(tsa_pkg::REG_CHAN_CFG, 8'h02);
    live_chk(8'h04, 1'b1);
    repeat (2) far.octet(8'h00, 1'b1);
    far.octet(8'hf0, 1'b1);
    live_chk(8'h00, 1'b1);
    far.octet(8'h80, 1'b1);
    live_chk(8'h04, 1'b1);
    rd_chk(tsa_pkg::REG_LATCHED, 8'h04);
    wr(tsa_pkg::REG_MASK, 8'h04);
    live_chk(8'h04, 1'b0);
    wr(tsa_pkg::REG_MASK, 8'h00);
    wr(tsa_pkg::REG_LATCHED, 8'h00);
    live_chk(8'h04, 1'b0);
    reset_dut();
    wr(tsa_pkg::REG_CHAN_CFG, 8'h02);
    repeat (15) far.octet(8'h00, 1'b0);
    live_chk(8'h00, 1'b0);
    far.octet(8'h00, 1'b0);
    live_chk(8'h04, 1'b1);
    reset_dut();
    wr(tsa_pkg::REG_CHAN_CFG, 8'h02);
    far.lvl(1'b1, 1'b0);
    live_chk(8'h04, 1'b1);
  endtask
  task automatic t_rai;
    reset_dut();
    repeat (2) far.octet(8'h04, 1'b1);
    live_chk(8'h00, 1'b0);
    far.octet(8'h04, 1'b1);
    live_chk(8'h10, 1'b1);
    wr(tsa_pkg::REG_GLOBAL, 8'h81);
    live_chk(8'h10, 1'b0);
    wr(tsa_pkg::REG_GLOBAL, 8'h41);
    live_chk(8'h10, 1'b0);
    reset_dut();
    wr(tsa_pkg::REG_GLOBAL, 8'h02);
    rai_words(8'h04);
    rd_chk(tsa_pkg::REG_LATCHED, 8'h00);
    rai_words(8'h00);
    rd_chk(tsa_pkg::REG_LATCHED, 8'h10);
  endtask
  task automatic t_shadow;
    reset_dut();
    wr(tsa_pkg::REG_GLOBAL, 8'h09);
    rai_words(8'h04);
    pulse();
    rd_chk(tsa_pkg::REG_SECOND, 8'h10);
    rd_chk(tsa_pkg::REG_PERSIST, 8'h00);
    rd_chk(tsa_pkg::REG_LATCHED, 8'h00);
    pulse();
    repeat (20) @(posedge clk_i);
    rd_chk(tsa_pkg::REG_PERSIST, 8'h10);
    rd_chk(tsa_pkg::REG_SECOND, 8'h10);
    wr(tsa_pkg::REG_GLOBAL, 8'h01);
    pulse();
    rd_chk(tsa_pkg::REG_SECOND, 8'h00);
    rd_chk(tsa_pkg::REG_PERSIST, 8'h00);
  endtask
  task automatic t_crc_ais;
    reset_dut();
    far.crc(914, 1'b1);
    live_chk(8'h00, 1'b0);
    far.crc(1, 1'b1);
    live_chk(8'h20, 1'b1);
    reset_dut();
    // one zero per multiframe; frame-0 bit position 2 kept clear so no slot RAI
    for (int m = 0; m < 3; m++) begin
      far.octet(8'hfb, 1'b1);
      if (m == 1) live_chk(8'h00, 1'b0);
      if (m < 2) repeat (15) far.octet(8'hff, 1'b0);
    end
    live_chk(8'h40, 1'b1);
    far.octet(8'h0f, 1'b1);
    live_chk(8'h00, 1'b1);
  endtask
  // windows land anywhere, so run just over two of them
  task automatic t_aux;
    reset_dut();
    wr(tsa_pkg::REG_CHAN_CFG, 8'h04);
    far.bits(2 * WIN + 10, 1'b1);
    live_chk(8'h01, 1'b1);
    far.lvl(1'b0, 1'b1);
    live_chk(8'h00, 1'b1);
    far.lvl(1'b0, 1'b0);
    far.bits(2 * WIN + 10, 1'b1);
    live_chk(8'h01, 1'b1);
    far.bits(2 * WIN + 10, 1'b0);
    live_chk(8'h00, 1'b1);
    wr(tsa_pkg::REG_CHAN_CFG, 8'h00);
    far.bits(2 * WIN + 10, 1'b1);
    live_chk(8'h00, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_i, cyc, stb, we, one_sec} = 5'h10;
    adr   = 12'h000;
    dat_w = 32'h0;
    t_regs();
    t_mfl();
    t_rai();
    t_shadow();
    t_crc_ais();
    t_aux();
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    end_of_test();
  end
endmodule
